/* verilog/rh_link_pkg.sv */
// Package with timing constants and field layout for the single-wire sensor link.
// Summary of operation
// - Sensor answers with 80 us low.
// - Then sensor holds line high 80 us.
// - Sensor sends exactly 40 bits back to back.
// - Zero bit: 50 us low, 26 us high.
// - One bit: 50 us low, 70 us high.
// - Final 50 us low, then release line.
// - After transfer, measure, store, then sleep; the link pulses meas_req_o and sleeps, loading held_ff only while asleep.
// - Sleeping sensor stays passive until wake-up low.
// - Bytes MSB first: humidity, temperature, check byte.
// - Check byte is sum of four bytes.
// - Temperature bit 15 is sign, rest magnitude.
package rh_link_pkg;
    localparam int CLK_MHZ = 200;
    localparam int T_WAKE_MIN_US = 800;
    localparam int T_RESP_LOW_US = 80;
    localparam int T_RESP_HIGH_US = 80;
    localparam int T_BIT_LOW_US = 50;
    localparam int T_HIGH0_US = 26;
    localparam int T_HIGH1_US = 70;
    localparam int T_END_LOW_US = 50;
    localparam int T_GO_US = 30;
    localparam int CYC_WAKE_MIN = T_WAKE_MIN_US * CLK_MHZ;
    localparam int CYC_RESP_LOW = T_RESP_LOW_US * CLK_MHZ;
    localparam int CYC_RESP_HIGH = T_RESP_HIGH_US * CLK_MHZ;
    localparam int CYC_BIT_LOW = T_BIT_LOW_US * CLK_MHZ;
    localparam int CYC_HIGH0 = T_HIGH0_US * CLK_MHZ;
    localparam int CYC_HIGH1 = T_HIGH1_US * CLK_MHZ;
    localparam int CYC_END_LOW = T_END_LOW_US * CLK_MHZ;
    localparam int CYC_GO = T_GO_US * CLK_MHZ;
    localparam int FRAME_BITS = 40;
    localparam int TEMP_SIGN_POS = 15;
    localparam int MEAS_W = 32;
    localparam int CNT_W = 18;
    localparam logic [MEAS_W-1:0] MEAS_RST = 32'h0000_0000;
endpackage

/* verilog/rh_meas_fifo.sv */
// Small flip-flop FIFO holding measurement words on their way to the link.
`timescale 1ns/1ps
module rh_meas_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    assign in_ready_o = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_ff != '0);
    assign out_data_o = mem_ff[rd_ff];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_sys_i) begin
        if (push) begin
            mem_ff[wr_ff] <= in_data_i;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= (wr_ff == AW'(DEPTH-1)) ? '0 : wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= (rd_ff == AW'(DEPTH-1)) ? '0 : rd_ff + 1'b1;
            end
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

/* verilog/rh_sensor_link.sv */
// Sensor side of the single-wire read transaction with measurement buffering.
`timescale 1ns/1ps
module rh_sensor_link #(
    parameter int DEPTH = 8,
    parameter int CYC_PER_US = rh_link_pkg::CLK_MHZ
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic meas_valid_i,
    output logic meas_ready_o,
    input wire logic [15:0] meas_hum_i,
    input wire logic meas_temp_neg_i,
    input wire logic [14:0] meas_temp_mag_i,
    output logic meas_req_o,
    output logic busy_o
);
    import rh_link_pkg::*;

    // Cycle counts follow the clock rate; CNT_W must still hold the wake-up count.
    localparam int L_WAKE = T_WAKE_MIN_US * CYC_PER_US;
    localparam int L_GO = T_GO_US * CYC_PER_US;
    localparam int L_RESP_LOW = T_RESP_LOW_US * CYC_PER_US;
    localparam int L_RESP_HIGH = T_RESP_HIGH_US * CYC_PER_US;
    localparam int L_BIT_LOW = T_BIT_LOW_US * CYC_PER_US;
    localparam int L_HIGH0 = T_HIGH0_US * CYC_PER_US;
    localparam int L_HIGH1 = T_HIGH1_US * CYC_PER_US;
    localparam int L_END_LOW = T_END_LOW_US * CYC_PER_US;

    // ****************************************
    // Functions
    // ****************************************
    function automatic logic [7:0] check_sum(input logic [MEAS_W-1:0] m);
        check_sum = m[31:24] + m[23:16] + m[15:8] + m[7:0];
    endfunction

    // ****************************************
    // Pin synchroniser
    // ****************************************
    logic sync1_ff;
    logic sync2_ff;
    logic sync3_ff;
    logic line_ff;
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            sync3_ff <= 1'b1;
            line_ff <= 1'b1;
        end else begin
            sync1_ff <= sda_i;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            if (sync2_ff == sync3_ff) begin
                line_ff <= sync3_ff;
            end
        end
    end

    // ****************************************
    // Measurement buffer
    // ****************************************
    logic fifo_valid;
    logic fifo_pop;
    logic [MEAS_W-1:0] fifo_data;
    logic [MEAS_W-1:0] fifo_in;
    // Sign in bit 15, magnitude below it.
    assign fifo_in = {meas_hum_i, meas_temp_neg_i, meas_temp_mag_i};

    rh_meas_fifo #(.WIDTH(MEAS_W), .DEPTH(DEPTH)) u_fifo (
        .clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i),
        .in_valid_i(meas_valid_i),
        .in_ready_o(meas_ready_o),
        .in_data_i(fifo_in),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    // ****************************************
    // Link sequencer
    // ****************************************
    typedef enum logic [3:0] {
        ST_SLEEP, ST_WAKE, ST_GO, ST_RLOW, ST_RHIGH, ST_BLOW, ST_BHIGH, ST_ELOW, ST_MEAS
    } state_t;

    state_t state_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic [5:0] bit_ff;
    logic [39:0] shift_ff;
    logic [MEAS_W-1:0] held_ff;
    logic drive_low_ff;
    logic req_ff;
    logic cnt_done;
    logic [CNT_W-1:0] high_len;

    assign high_len = shift_ff[39] ? CNT_W'(L_HIGH1) : CNT_W'(L_HIGH0);
    assign cnt_done = (cnt_ff == '0);
    // Only the last stored measurement is held; reads return the previous result.
    assign fifo_pop = fifo_valid && (state_ff == ST_SLEEP);

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            held_ff <= MEAS_RST;
        end else if (fifo_pop) begin
            held_ff <= fifo_data;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_SLEEP;
            cnt_ff <= '0;
            bit_ff <= '0;
            shift_ff <= '0;
        end else begin
            if (!cnt_done) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
            unique case (state_ff)
                ST_SLEEP: begin
                    // Passive until a low appears on the line.
                    if (!line_ff) begin
                        state_ff <= ST_WAKE;
                        // Loaded one short so a low of exactly the minimum is accepted.
                        cnt_ff <= CNT_W'(L_WAKE - 1);
                    end
                end
                ST_WAKE: begin
                    // A short glitch returns to sleep instead of answering.
                    if (line_ff) begin
                        state_ff <= cnt_done ? ST_GO : ST_SLEEP;
                        cnt_ff <= CNT_W'(L_GO);
                    end
                end
                ST_GO: begin
                    if (cnt_done) begin
                        state_ff <= ST_RLOW;
                        cnt_ff <= CNT_W'(L_RESP_LOW);
                        shift_ff <= {held_ff, check_sum(held_ff)};
                    end
                end
                ST_RLOW: begin
                    if (cnt_done) begin
                        state_ff <= ST_RHIGH;
                        cnt_ff <= CNT_W'(L_RESP_HIGH);
                    end
                end
                ST_RHIGH: begin
                    if (cnt_done) begin
                        state_ff <= ST_BLOW;
                        cnt_ff <= CNT_W'(L_BIT_LOW);
                        bit_ff <= '0;
                    end
                end
                ST_BLOW: begin
                    if (cnt_done) begin
                        state_ff <= ST_BHIGH;
                        cnt_ff <= high_len;
                    end
                end
                ST_BHIGH: begin
                    if (cnt_done) begin
                        shift_ff <= {shift_ff[38:0], 1'b0};
                        bit_ff <= bit_ff + 1'b1;
                        cnt_ff <= CNT_W'(L_BIT_LOW);
                        // Exactly forty bits, then the closing low.
                        state_ff <= (bit_ff == 6'(FRAME_BITS-1)) ? ST_ELOW : ST_BLOW;
                        if (bit_ff == 6'(FRAME_BITS-1)) begin
                            cnt_ff <= CNT_W'(L_END_LOW);
                        end
                    end
                end
                ST_ELOW: begin
                    if (cnt_done) begin
                        state_ff <= ST_MEAS;
                    end
                end
                ST_MEAS: begin
                    // Wait for the released line to float high before sleeping.
                    if (line_ff) begin
                        state_ff <= ST_SLEEP;
                    end
                end
                default: begin
                    state_ff <= ST_SLEEP;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            drive_low_ff <= 1'b0;
            req_ff <= 1'b0;
        end else begin
            drive_low_ff <= (state_ff == ST_RLOW) || (state_ff == ST_BLOW)
                || (state_ff == ST_ELOW);
            // Ask for a new measurement only once the closing low has been let go.
            req_ff <= (state_ff == ST_MEAS) && drive_low_ff;
        end
    end

    // Open drain: high is never driven, the pull-up supplies it.
    assign sda_o = 1'b0;
    assign sda_oe_o = drive_low_ff;
    assign meas_req_o = req_ff;
    assign busy_o = (state_ff != ST_SLEEP);
endmodule

/* testbench/rh_link_checker.sv */
// Port checker for the sensor side of the single-wire link.
`timescale 1ns/1ps
module rh_link_checker
    import rh_link_pkg::*;
#(
    parameter int CYC_PER_US = CLK_MHZ
) (
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic meas_req_o,
    input wire logic busy_o
);
    // ********
    // Pulse timers
    // ********
    localparam int W_WAKE = T_WAKE_MIN_US * CYC_PER_US;
    localparam int W_RESP = T_RESP_LOW_US * CYC_PER_US;
    localparam int W_RHIGH = T_RESP_HIGH_US * CYC_PER_US;
    localparam int W_BLOW = T_BIT_LOW_US * CYC_PER_US;
    localparam int W_END = T_END_LOW_US * CYC_PER_US;
    localparam int W_H0 = T_HIGH0_US * CYC_PER_US;
    localparam int W_H1 = T_HIGH1_US * CYC_PER_US;
    logic [17:0] hi_ff, rel_ff, lo_ff, last_ff;
    logic [5:0] np_ff;
    logic had_ff;
    // Run lengths are kept so one check serves every pulse of the frame.
    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hi_ff <= '0;
            rel_ff <= '0;
            lo_ff <= '0;
            last_ff <= '0;
            np_ff <= '0;
            had_ff <= 1'b0;
        end else begin
            hi_ff <= sda_oe_o ? hi_ff + 18'h1 : '0;
            rel_ff <= sda_oe_o ? '0 : rel_ff + 18'h1;
            lo_ff <= sda_i ? '0 : lo_ff + {17'h0, ~&lo_ff};
            last_ff <= (sda_i && lo_ff != '0) ? lo_ff : last_ff;
            np_ff <= busy_o ? np_ff + {5'h0, sda_oe_o && hi_ff == '0} : '0;
            had_ff <= busy_o && (had_ff || sda_oe_o);
        end
    end
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);
    property p_drv; sda_o == 1'b0; endproperty
    a_drv: assert property (p_drv) else $error("data out not low");
    property p_quiet; !busy_o |-> !sda_oe_o; endproperty
    a_quiet: assert property (p_quiet) else $error("drive while asleep");
    property p_wake; $rose(sda_oe_o) && !had_ff |-> $past(sda_i) && last_ff >= W_WAKE; endproperty
    a_wake: assert property (p_wake) else $error("answer without wake");
    property p_low;
        $fell(sda_oe_o) |-> hi_ff inside {[W_BLOW-1:W_BLOW+1], [W_RESP-1:W_RESP+1],
            [W_END-1:W_END+1]};
    endproperty
    a_low: assert property (p_low) else $error("low length");
    property p_rel;
        $rose(sda_oe_o) && had_ff |-> rel_ff inside {[W_H0-1:W_H0+1], [W_H1-1:W_H1+1],
            [W_RHIGH-1:W_RHIGH+1]};
    endproperty
    a_rel: assert property (p_rel) else $error("high length");
    property p_cnt; meas_req_o |-> np_ff == 6'd42; endproperty
    a_cnt: assert property (p_cnt) else $error("pulse count");
    property p_idle; meas_req_o |-> !sda_oe_o; endproperty
    a_idle: assert property (p_idle) else $error("request while driving");
    property p_once; meas_req_o |=> !meas_req_o [*8]; endproperty
    a_once: assert property (p_once) else $error("request too long");
    c_resp: cover property ($rose(sda_oe_o) && !had_ff);
    c_req: cover property (meas_req_o);
    c_sleep: cover property ($fell(busy_o));
endmodule

/* testbench/rh_host_model.sv */
// Host model: wakes the sensor and decodes its frame by timing highs.
`timescale 1ns/1ps
module rh_host_model #(
    parameter int CYC_PER_US = 200
) (
    input wire logic clk_sys_i,
    input wire logic start_i,
    input wire logic [17:0] wake_cyc_i,
    input wire logic line_i,
    output logic host_oe_o,
    output logic [39:0] frame_o,
    output logic done_o,
    output logic err_o
);
    // ********
    // Read sequence
    // ********
    int n;
    // Split between zero and one highs, and the longest wait for any edge.
    localparam int N_SPLIT = 48 * CYC_PER_US;
    localparam int N_LIMIT = 120 * CYC_PER_US;
    initial {host_oe_o, done_o, err_o} = 3'b0;
    // Bounded waits let a silent sensor end the read, not the run.
    task automatic wait_lvl(input logic lvl);
        n = 0;
        while (!err_o && line_i !== lvl) begin
            @(posedge clk_sys_i);
            n++;
            err_o = n >= N_LIMIT;
        end
    endtask
    always @(posedge clk_sys_i) begin
        if (start_i) begin
            done_o = 1'b0;
            err_o = 1'b0;
            host_oe_o <= 1'b1;
            repeat (wake_cyc_i) @(posedge clk_sys_i);
            host_oe_o <= 1'b0;
            wait_lvl(1'b1);
            wait_lvl(1'b0);
            wait_lvl(1'b1);
            wait_lvl(1'b0);
            for (int i = 0; i < 40; i++) begin
                wait_lvl(1'b1);
                wait_lvl(1'b0);
                frame_o = {frame_o[38:0], n > N_SPLIT};
            end
            wait_lvl(1'b1);
            done_o = 1'b1;
        end
    end
endmodule

/* testbench/rh_sensor_link_test.sv */
// Top testbench of the sensor link with host model and checker.
`timescale 1ns/1ps
module rh_sensor_link_test;
    import rh_link_pkg::*;
    // Two cycles per microsecond keep whole frames short in simulation.
    localparam int CYC_PER_US = 2;
    // ********
    // Bench
    // ********
    logic clk_sys_i = 1'b0, reset_n_i = 1'b0, meas_valid_i = 1'b0, start = 1'b0;
    logic [31:0] meas_w = '0;
    logic [17:0] wake_cyc = '0;
    logic host_oe, sda, sda_oe_o, meas_ready_o, meas_req_o, busy_o, done, err;
    logic [39:0] frame;
    int n_fail = 0;
    int checked = 0;
    int n_req = 0;
    assign sda = !(host_oe || sda_oe_o);
    always @(posedge clk_sys_i) begin
        if (meas_req_o === 1'b1) begin
            n_req <= n_req + 1;
        end
    end
    rh_sensor_link #(.CYC_PER_US(CYC_PER_US)) rh_sensor_link_i (.clk_sys_i(clk_sys_i),
        .reset_n_i(reset_n_i), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe_o),
        .meas_valid_i(meas_valid_i), .meas_ready_o(meas_ready_o), .meas_hum_i(meas_w[31:16]),
        .meas_temp_neg_i(meas_w[15]), .meas_temp_mag_i(meas_w[14:0]), .meas_req_o(meas_req_o),
        .busy_o(busy_o));
    rh_host_model #(.CYC_PER_US(CYC_PER_US)) rh_host_model_i (.clk_sys_i(clk_sys_i),
        .start_i(start),
        .wake_cyc_i(wake_cyc), .line_i(sda), .host_oe_o(host_oe), .frame_o(frame),
        .done_o(done), .err_o(err));
    function automatic logic [39:0] fr(input logic [31:0] w);
        return {w, w[31:24] + w[23:16] + w[15:8] + w[7:0]};
    endfunction
    task automatic check(input string nm, input logic [39:0] s, input logic [39:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic push(input logic [31:0] w);
        meas_valid_i <= 1'b1;
        meas_w <= w;
        @(negedge clk_sys_i);
        while (meas_ready_o !== 1'b1) @(negedge clk_sys_i);
        @(posedge clk_sys_i);
    endtask
    // Reads are spaced far closer than two seconds; the sensor never times the gap.
    task automatic read(input logic [17:0] wk);
        int k;
        k = 0;
        start <= 1'b1;
        wake_cyc <= wk;
        @(posedge clk_sys_i);
        start <= 1'b0;
        do begin
            @(negedge clk_sys_i);
            k++;
        end while (done !== 1'b1 && err !== 1'b1 && k < 15000 * CYC_PER_US);
        check("end", {39'h0, done || err}, 40'h1);
        repeat (10) @(posedge clk_sys_i);
    endtask
    task automatic t_short;
        read(18'(T_WAKE_MIN_US * CYC_PER_US - 1));
        check("err", {39'h0, err}, 40'h1);
        check("busy", {39'h0, busy_o}, 40'h0);
        $display("t_short done");
    endtask
    task automatic t_read1;
        push(32'h0292_010D);
        meas_valid_i <= 1'b0;
        repeat (20) @(posedge clk_sys_i);
        fork
            read(18'(1000 * CYC_PER_US));
            begin
                repeat (1100 * CYC_PER_US) @(posedge clk_sys_i);
                for (int i = 0; i < 8; i++) push(32'h0123_8060 + i);
                meas_valid_i <= 1'b0;
                @(negedge clk_sys_i);
                check("ready", {39'h0, meas_ready_o}, 40'h0);
            end
        join
        check("frame", frame, fr(32'h0292_010D));
        $display("t_read1 done");
    endtask
    task automatic t_read2;
        repeat (100) @(posedge clk_sys_i);
        check("ready", {39'h0, meas_ready_o}, 40'h1);
        read(18'(T_WAKE_MIN_US * CYC_PER_US));
        check("frame", frame, fr(32'h0123_8067));
        check("busy", {39'h0, busy_o}, 40'h0);
        check("req", 40'(n_req), 40'd2);
        $display("t_read2 done");
    endtask
    task automatic finish_test;
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (20) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        @(posedge clk_sys_i);
        t_short;
        t_read1;
        t_read2;
        finish_test;
    end
    // Three scaled reads take about 105 microseconds.
    initial begin
        #300000;
        n_fail++;
        finish_test;
    end
endmodule
bind rh_sensor_link rh_link_checker #(.CYC_PER_US(CYC_PER_US)) rh_link_checker_i (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .meas_req_o(meas_req_o), .busy_o(busy_o));
